// ===== spt_cfg.svh
`ifndef SPT_CFG_SVH
`define SPT_CFG_SVH

// Register byte offsets
`define SPT_OFS_CTRL        8'h00
`define SPT_OFS_SCR_BASE    8'h04
`define SPT_OFS_SCR_STEP    8'h04
`define SPT_OFS_PAUSE       8'h14
`define SPT_OFS_SWTRIG      8'h18
`define SPT_OFS_STATUS      8'h1C

// Field positions
`define SPT_CTRL_OP_LSB     0
`define SPT_SCR_MODE_LSB    0
`define SPT_SCR_SRC_LSB     2
`define SPT_SCR_POL_BIT     6
`define SPT_PSE_EN_BIT      0
`define SPT_PSE_SRC_LSB     1
`define SPT_PSE_POL_BIT     5
`define SPT_STAT_TRIG_LSB   0
`define SPT_STAT_PAUSE_BIT  4
`define SPT_STAT_LINES_LSB  8

// Reset values
`define SPT_RST_OP          2'h0
`define SPT_RST_SRC         4'h0
`define SPT_RST_POL         1'h0
`define SPT_RST_PSE_EN      1'h0

// Source encodings
`define SPT_SRC_PFI0        4'h0
`define SPT_SRC_TBL0        4'h4
`define SPT_SRC_STAR        4'hC

// Synchroniser depth in sample clock cycles
`define SPT_SYNC_STAGES     2

`endif

// ===== spt_line_model.sv
`timescale 1ns/100ps
`default_nettype none

module spt_line_model
#(
  parameter int DELAY_NS = 3
)
(
  input  wire logic            i_clk_sys,
  input  wire spt_pkg::spt_lines_t i_want,
  output var  spt_pkg::spt_lines_t o_lines
);
  import spt_pkg::*;

  // Lines move between sample edges, as an unrelated source would
  initial
  begin
    o_lines = '0;
  end

  always @(posedge i_clk_sys)
  begin
    o_lines <= #(DELAY_NS) i_want;
  end
endmodule : spt_line_model

`default_nettype wire

// ===== spt_pkg.sv
package spt_pkg;

  localparam int SPT_NUM_SCRIPT = 4;
  localparam int SPT_NUM_PFI    = 4;
  localparam int SPT_NUM_TBL    = 8;
  localparam int SPT_NUM_LINES  = SPT_NUM_PFI + SPT_NUM_TBL + 1;

  typedef enum logic [1:0] {
    SPT_MODE_OFF   = 2'h0,
    SPT_MODE_EDGE  = 2'h1,
    SPT_MODE_LEVEL = 2'h2,
    SPT_MODE_SW    = 2'h3
  } spt_mode_t;

  typedef enum logic [1:0] {
    SPT_OP_IDLE = 2'h0,
    SPT_OP_GEN  = 2'h1,
    SPT_OP_ACQ  = 2'h2
  } spt_op_t;

  // Trigger lines as they arrive, function pins in the low bits
  typedef struct packed {
    logic                    star;
    logic [SPT_NUM_TBL-1:0]  tbl;
    logic [SPT_NUM_PFI-1:0]  programmable_function_pin;
  } spt_lines_t;

  typedef struct packed {
    logic       pol;
    logic [3:0] src;
    spt_mode_t  mode;
  } spt_script_cfg_t;

  typedef struct packed {
    logic       pol;
    logic [3:0] src;
    logic       en;
  } spt_pause_cfg_t;

endpackage : spt_pkg

// ===== spt_sync.sv
`timescale 1ns/100ps
`default_nettype none

module spt_sync
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire spt_pkg::spt_lines_t  i_async,
  output var  spt_pkg::spt_lines_t  o_sync
);

  import spt_pkg::*;

  spt_lines_t meta_q;
  spt_lines_t meta_d;
  spt_lines_t sync_q;
  spt_lines_t sync_d;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;

endmodule : spt_sync

`default_nettype wire

// ===== spt_trigger_detect.sv
//
// Behaviour
// R01: Four script trigger instances 0..3, each with own source, mode and polarity.
// R02: Edge mode available; script triggers act only while generation runs.
// R03: Edge mode fires one pulse on the chosen rising or falling transition.
// R04: Source is function pin 0..3, timing bus line 0..7 or star line.
// R05: Level mode makes the trigger a continuous condition following the source.
// R06: High polarity: trigger active exactly while sampled source is high.
// R07: Low polarity: trigger active exactly while sampled source is low.
// R08: Software mode ignores lines, fires only on a host command for it.
// R09: Disabled instance never fires, whatever the lines or commands.
// R10: Pause trigger is a level trigger from its own source and polarity.
// R11: All external lines pass a two-stage synchroniser before evaluation.
`include "spt_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module spt_trigger_detect
(
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_rst,
  input  wire logic [spt_pkg::SPT_NUM_PFI-1:0]      i_programmable_function_pin,
  input  wire logic [spt_pkg::SPT_NUM_TBL-1:0]      i_timing_bus_line,
  input  wire logic                                 i_backplane_star_line,
  input  wire logic [7:0]                           i_addr,
  input  wire logic [31:0]                          i_wdata,
  input  wire logic                                 i_wr,
  input  wire logic                                 i_rd,
  output logic      [31:0]                          o_rdata,
  output logic      [spt_pkg::SPT_NUM_SCRIPT-1:0]   o_script_trig,
  output logic                                      o_pause
);

  import spt_pkg::*;

  spt_lines_t      pins;
  spt_lines_t      line_s;
  spt_lines_t      prev_q;
  spt_lines_t      prev_d;
  spt_op_t         op_q;
  spt_op_t         op_d;
  spt_script_cfg_t scr_q [SPT_NUM_SCRIPT];
  spt_script_cfg_t scr_d [SPT_NUM_SCRIPT];
  spt_pause_cfg_t  pse_q;
  spt_pause_cfg_t  pse_d;
  logic [SPT_NUM_SCRIPT-1:0] sw_cmd;
  logic [SPT_NUM_SCRIPT-1:0] sel_now;
  logic [SPT_NUM_SCRIPT-1:0] sel_prev;
  logic [SPT_NUM_SCRIPT-1:0] trig_q;
  logic [SPT_NUM_SCRIPT-1:0] trig_d;
  logic                      pse_sel;
  logic                      pause_q;
  logic                      pause_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic                      gen_run;

  // Picks one line by source code; unused codes read as low
  function automatic logic line_pick(input spt_lines_t lines, input logic [3:0] src);
    logic [SPT_NUM_LINES-1:0] v;
    v = lines;
    if (src <= `SPT_SRC_STAR)
      line_pick = v[src];
    else
      line_pick = 1'b0;
  endfunction : line_pick

  // Byte address of a script configuration register
  function automatic logic [7:0] scr_addr(input int idx);
    scr_addr = `SPT_OFS_SCR_BASE + 8'(idx) * `SPT_OFS_SCR_STEP;
  endfunction : scr_addr

  assign pins.programmable_function_pin  = i_programmable_function_pin;
  assign pins.tbl  = i_timing_bus_line;
  assign pins.star = i_backplane_star_line;

  spt_sync u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (pins),
    .o_sync    (line_s)            // R11
  );

  // Register writes and host commands
  always_comb
  begin
    op_d   = op_q;
    pse_d  = pse_q;
    sw_cmd = '0;
    for (int i = 0; i < SPT_NUM_SCRIPT; i++)
    begin
      scr_d[i] = scr_q[i];
    end
    if (i_wr)
    begin
      if (i_addr == `SPT_OFS_CTRL)
        op_d = spt_op_t'(i_wdata[`SPT_CTRL_OP_LSB +: 2]);
      if (i_addr == `SPT_OFS_PAUSE)
      begin
        pse_d.en  = i_wdata[`SPT_PSE_EN_BIT];
        pse_d.src = i_wdata[`SPT_PSE_SRC_LSB +: 4];
        pse_d.pol = i_wdata[`SPT_PSE_POL_BIT];
      end
      if (i_addr == `SPT_OFS_SWTRIG)
        sw_cmd = i_wdata[SPT_NUM_SCRIPT-1:0];
      for (int i = 0; i < SPT_NUM_SCRIPT; i++)
      begin
        if (i_addr == scr_addr(i))
        begin
          scr_d[i].mode = spt_mode_t'(i_wdata[`SPT_SCR_MODE_LSB +: 2]);   // R01
          scr_d[i].src  = i_wdata[`SPT_SCR_SRC_LSB +: 4];
          scr_d[i].pol  = i_wdata[`SPT_SCR_POL_BIT];
        end
      end
    end
  end

  assign gen_run = (op_q == SPT_OP_GEN);

  // Source selection per instance and for pause
  always_comb
  begin
    for (int i = 0; i < SPT_NUM_SCRIPT; i++)
    begin
      sel_now[i]  = line_pick(line_s, scr_q[i].src);   // R04
      sel_prev[i] = line_pick(prev_q, scr_q[i].src);
    end
    pse_sel = line_pick(line_s, pse_q.src);          // R04
  end

  // Trigger evaluation
  always_comb
  begin
    prev_d = line_s;
    for (int i = 0; i < SPT_NUM_SCRIPT; i++)
    begin
      trig_d[i] = 1'b0;
      if (gen_run)                                   // R02
      begin
        case (scr_q[i].mode)
          SPT_MODE_EDGE:
            if (scr_q[i].pol)
              trig_d[i] = sel_prev[i] & ~sel_now[i];  // R03
            else
              trig_d[i] = ~sel_prev[i] & sel_now[i];  // R03
          SPT_MODE_LEVEL:
            trig_d[i] = sel_now[i] ^ scr_q[i].pol;   // R05 R06 R07
          SPT_MODE_SW:
            trig_d[i] = sw_cmd[i];                   // R08
          SPT_MODE_OFF:
            trig_d[i] = 1'b0;                        // R09
          default:
            trig_d[i] = 1'b0;
        endcase
      end
    end
    // Pause holds during any running data operation
    pause_d = pse_q.en && (op_q != SPT_OP_IDLE) && (pse_sel ^ pse_q.pol);   // R10
  end

  // Read path, data valid only in the cycle after the strobe
  always_comb
  begin
    rdata_d = '0;
    if (i_rd)
    begin
      if (i_addr == `SPT_OFS_CTRL)
        rdata_d[`SPT_CTRL_OP_LSB +: 2] = op_q;
      if (i_addr == `SPT_OFS_PAUSE)
      begin
        rdata_d[`SPT_PSE_EN_BIT]         = pse_q.en;
        rdata_d[`SPT_PSE_SRC_LSB +: 4]   = pse_q.src;
        rdata_d[`SPT_PSE_POL_BIT]        = pse_q.pol;
      end
      if (i_addr == `SPT_OFS_STATUS)
      begin
        rdata_d[`SPT_STAT_TRIG_LSB +: SPT_NUM_SCRIPT]  = trig_q;
        rdata_d[`SPT_STAT_PAUSE_BIT]                   = pause_q;
        rdata_d[`SPT_STAT_LINES_LSB +: SPT_NUM_LINES]  = line_s;
      end
      for (int i = 0; i < SPT_NUM_SCRIPT; i++)
      begin
        if (i_addr == scr_addr(i))
        begin
          rdata_d[`SPT_SCR_MODE_LSB +: 2] = scr_q[i].mode;
          rdata_d[`SPT_SCR_SRC_LSB +: 4]  = scr_q[i].src;
          rdata_d[`SPT_SCR_POL_BIT]       = scr_q[i].pol;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      op_q    <= spt_op_t'(`SPT_RST_OP);
      pse_q   <= '{pol: `SPT_RST_POL, src: `SPT_RST_SRC, en: `SPT_RST_PSE_EN};
      prev_q  <= '0;
      trig_q  <= '0;
      pause_q <= 1'b0;
      rdata_q <= '0;
      for (int i = 0; i < SPT_NUM_SCRIPT; i++)
      begin
        scr_q[i] <= '{pol: `SPT_RST_POL, src: `SPT_RST_SRC, mode: SPT_MODE_OFF};
      end
    end
    else
    begin
      op_q    <= op_d;
      pse_q   <= pse_d;
      prev_q  <= prev_d;
      trig_q  <= trig_d;
      pause_q <= pause_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < SPT_NUM_SCRIPT; i++)
      begin
        scr_q[i] <= scr_d[i];
      end
    end
  end

  assign o_rdata       = rdata_q;
  assign o_script_trig = trig_q;
  assign o_pause       = pause_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_pins_into_sync;
    1'b1 ##2 1'b1;
  endsequence

  a_sync_two_stage: assert property (   // R11
    s_pins_into_sync |-> (line_s == $past(pins, 2)))
    else $error("synchronised lines do not lag the pins by two cycles");

  a_pause_follows: assert property (   // R10
    (pse_q.en && op_q != SPT_OP_IDLE && $stable(pse_q))
      |=> (o_pause == ($past(pse_sel) ^ $past(pse_q.pol))))
    else $error("pause does not follow its selected source level");

  a_pause_off_quiet: assert property (   // R10
    (!pse_q.en || op_q == SPT_OP_IDLE) |=> !o_pause)
    else $error("pause active while disabled or idle");

  for (genvar g = 0; g < SPT_NUM_SCRIPT; g++)
  begin : g_chk
    sequence s_src_rise;
      (!sel_now[g]) ##1 (sel_now[g] && $stable(scr_q[g]));
    endsequence

    sequence s_src_fall;
      sel_now[g] ##1 (!sel_now[g] && $stable(scr_q[g]));
    endsequence

    a_edge_rise: assert property (   // R03
      (s_src_rise ##0 (gen_run && scr_q[g].mode == SPT_MODE_EDGE && !scr_q[g].pol))
        |=> o_script_trig[g])
      else $error("rising edge on source missed");

    a_edge_fall: assert property (   // R03
      (s_src_fall ##0 (gen_run && scr_q[g].mode == SPT_MODE_EDGE && scr_q[g].pol))
        |=> o_script_trig[g])
      else $error("falling edge on source missed");

    a_edge_one_shot: assert property (   // R03
      (scr_q[g].mode == SPT_MODE_EDGE && o_script_trig[g]) |=> !o_script_trig[g]
        or (scr_q[g].mode != SPT_MODE_EDGE))
      else $error("edge trigger held longer than one cycle");

    a_level_high: assert property (   // R06
      (gen_run && scr_q[g].mode == SPT_MODE_LEVEL && !scr_q[g].pol)
        |=> (o_script_trig[g] == $past(sel_now[g])))
      else $error("high level trigger does not follow source");

    a_level_low: assert property (   // R07
      (gen_run && scr_q[g].mode == SPT_MODE_LEVEL && scr_q[g].pol)
        |=> (o_script_trig[g] == !$past(sel_now[g])))
      else $error("low level trigger does not follow inverted source");

    a_sw_cmd_fires: assert property (   // R08
      (gen_run && scr_q[g].mode == SPT_MODE_SW && sw_cmd[g]) |=> o_script_trig[g])
      else $error("software command did not fire its trigger");

    a_sw_ignores_line: assert property (   // R08
      (scr_q[g].mode == SPT_MODE_SW && !sw_cmd[g]) |=> !o_script_trig[g])
      else $error("software trigger fired without a command");

    a_disabled_quiet: assert property (   // R09
      (scr_q[g].mode == SPT_MODE_OFF) |=> !o_script_trig[g])
      else $error("disabled script trigger fired");

    a_gen_only: assert property (   // R02
      (!gen_run) |=> !o_script_trig[g])
      else $error("script trigger fired outside generation");
  end

endmodule : spt_trigger_detect

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "spt_cfg.svh"

module tb_top;
  import spt_pkg::*;

  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        rd_seen    = 1'b0;
  logic [31:0] rdata;
  logic [3:0]  trig;
  logic        pause;
  spt_lines_t  want       = '0;
  spt_lines_t  lines;
  logic [31:0] exp_q[$];
  int          cnt [4];
  int          mismatches = 0;
  int          num_checks = 0;
  integer      seed       = 32'h8361;
  int          i;
  int          n;
  logic [1:0]  op;
  logic [3:0]  src [4];
  logic        pol [4];
  logic [31:0] w;
  logic [31:0] pw;
  logic [3:0]  te;
  logic        pe;
  logic [31:0] etab [4]   = '{32'h01, 32'h41, 32'h03, 32'h00};
  int          ecnt [4]   = '{1, 1, 2, 0};

  initial
  begin
    forever #4 clk = ~clk;
  end

  spt_line_model #(.DELAY_NS(3)) u_far (
    .i_clk_sys (clk),
    .i_want    (want),
    .o_lines   (lines)
  );

  spt_trigger_detect u_dut (
    .i_clk_sys                   (clk),
    .i_rst                       (rst),
    .i_programmable_function_pin (lines.programmable_function_pin),
    .i_timing_bus_line           (lines.tbl),
    .i_backplane_star_line       (lines.star),
    .i_addr                      (addr),
    .i_wdata                     (wdata),
    .i_wr                        (wr),
    .i_rd                        (rd),
    .o_rdata                     (rdata),
    .o_script_trig               (trig),
    .o_pause                     (pause)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic close_out;
    $display("mismatches %0d of %0d checks", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg

  function automatic logic lvl(input spt_lines_t l, input logic [3:0] s);
    logic [12:0] v;
    v = l;
    return (s <= 4'hC) ? v[s] : 1'b0;
  endfunction : lvl

  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_seen && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front());
    rd_seen <= rd;
    for (int k = 0; k < 4; k++)
      if (trig[k] === 1'b1)
        cnt[k] = cnt[k] + 1;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++)
      rd_reg(8'(4 * i), 32'h0);
    wr_reg(8'h24, 32'hFFFFFFFF);
    rd_reg(8'h24, 32'h0);
    for (n = 0; n < 24; n++)
    begin
      op = 2'($random(seed));
      wr_reg(`SPT_OFS_CTRL, {30'h0, op});
      for (i = 0; i < 4; i++)
      begin
        w = $random(seed);
        w[1:0] = SPT_MODE_LEVEL;
        src[i] = w[5:2];
        pol[i] = w[6];
        wr_reg(`SPT_OFS_SCR_BASE + 8'(i * 4), w);
      end
      pw = $random(seed);
      wr_reg(`SPT_OFS_PAUSE, pw);
      want <= 13'($random(seed));
      repeat (8) @(posedge clk);
      for (i = 0; i < 4; i++)
        te[i] = (op == 2'h1) & (lvl(want, src[i]) ^ pol[i]);
      pe = pw[0] & (lvl(want, pw[4:1]) ^ pw[5]) & (op != 2'h0);
      chk({27'h0, pause, trig}, {27'h0, pe, te});
      rd_reg(`SPT_OFS_STATUS, {11'h0, want, 3'h0, pe, te});
      rd_reg(`SPT_OFS_SCR_BASE + 8'h0C, {25'h0, w[6:0]});
      rd_reg(`SPT_OFS_PAUSE, {26'h0, pw[5:0]});
    end
    // Edge, software and disabled instances all watch function pin 0
    wr_reg(`SPT_OFS_CTRL, 32'h1);
    want <= '0;
    for (i = 0; i < 4; i++)
      wr_reg(`SPT_OFS_SCR_BASE + 8'(i * 4), etab[i]);
    repeat (8) @(posedge clk);
    cnt = '{default: 0};
    want.programmable_function_pin[0] <= 1'b1;
    repeat (8) @(posedge clk);
    want.programmable_function_pin[0] <= 1'b0;
    repeat (8) @(posedge clk);
    wr_reg(`SPT_OFS_SWTRIG, 32'hF);
    wr_reg(`SPT_OFS_SWTRIG, 32'hF);
    wr_reg(`SPT_OFS_CTRL, 32'h2);
    wr_reg(`SPT_OFS_SWTRIG, 32'hF);
    repeat (4) @(posedge clk);
    for (i = 0; i < 4; i++)
      chk(32'(cnt[i]), 32'(ecnt[i]));
    close_out();
  end
endmodule : tb_top

`default_nettype wire
